/* verif/aocr_regs_tb.sv */
// self-checking bench for the output configuration register bank
module aocr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wr_addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_addr = 8'h00;
  logic [11:0] smp_a = 12'h100;
  logic [11:0] smp_b = 12'h200;
  logic [7:0] rd_data;
  logic [11:0] dat_a;
  logic [11:0] dat_b;
  logic en_a;
  logic en_b;
  logic [1:0] st_start;
  logic [1:0] st_reinit;
  logic [1:0] lvl;
  int errors = 0;
  int num_checks = 0;
  logic [7:0] trims [4] = '{8'h05, 8'hff, 8'h7f, 8'h80};
  logic [11:0] w0, wa, wb;

  aocr_regs #(.DATA_W(12)) aocr_regs_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_en_in(wr_en), .wr_addr_in(wr_addr),
    .wr_data_in(wr_data), .rd_en_in(rd_en), .rd_addr_in(rd_addr), .sample_a_in(smp_a),
    .sample_b_in(smp_b), .rd_data_out(rd_data), .data_a_out(dat_a), .data_b_out(dat_b),
    .data_a_en_out(en_a), .data_b_en_out(en_b), .self_test_start_out(st_start),
    .self_test_reinit_out(st_reinit), .io_level_out(lvl)
  );

  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // inputs move 1 ns after the edge so no race with the design's sampling
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick

  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_word(input string nm, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    tick();
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    tick();
    rd_en = 1'b1;
    rd_addr = a;
    tick();
    rd_en = 1'b0;
    chk_reg(nm, e, rd_data);
  endtask : rd

  // clamping at the rails chosen over wrap-around on trim overflow
  function automatic logic [11:0] exp_word(input logic [11:0] s, input logic [7:0] t, input logic [1:0] f);
    int v;
    logic [11:0] w;
    v = int'(s) + int'($signed(t));
    v = (v < 0) ? 0 : ((v > 4095) ? 4095 : v);
    w = v[11:0];
    if (f == 2'b01) w[11] = ~w[11];
    if (f == 2'b10) w = w ^ (w >> 1);
    return w;
  endfunction : exp_word

  // samples are held steady, so four cycles cover the two-cycle path
  task automatic chk_data(input logic [7:0] ta, input logic [7:0] tb, input logic [1:0] f);
    repeat (4) tick();
    chk_word("word a", exp_word(smp_a, ta, f), dat_a);
    chk_word("word b", exp_word(smp_b, tb, f), dat_b);
  endtask : chk_data

  task automatic st_probe(input logic [7:0] d, input logic [7:0] e);
    int k;
    k = 0;
    wr(8'h0e, d);
    repeat (6) begin
      tick();
      if (st_start === 2'b11) k++;
    end
    chk_reg("start pulses", e, k[7:0]);
  endtask : st_probe

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (10) tick();
    rst_in = 1'b0;
    rd(8'h05, 8'h03, "chan index");
    rd(8'h0e, 8'h00, "self test");
    rd(8'h10, 8'h00, "trim");
    rd(8'h14, 8'h00, "out config");
    rd(8'h33, 8'h00, "unmapped");
    chk_reg("enables level", 8'h0c, {4'h0, en_a, en_b, lvl});
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        smp_a = 12'hff0;
        smp_b = 12'h010;
      end
      for (int f = 0; f < 4; f++) begin
        for (int i = 0; i < 4; i++) begin
          wr(8'h10, trims[i]);
          wr(8'h14, {6'h00, f[1:0]});
          chk_data(trims[i], trims[i], f[1:0]);
        end
      end
    end
    rd(8'h10, 8'h80, "trim readback");
    wr(8'h14, 8'h00);
    // zero sample with the most negative trim hits the low rail
    smp_a = 12'h000;
    smp_b = 12'h200;
    wr(8'h05, 8'h02);
    wr(8'h10, 8'h11);
    chk_data(8'h80, 8'h11, 2'b00);
    rd(8'h05, 8'h02, "chan index");
    wr(8'h05, 8'h01);
    rd(8'h10, 8'h80, "trim a");
    smp_a = 12'h100;
    wr(8'h14, 8'h10);
    repeat (4) tick();
    chk_reg("disable", 8'h01, {6'h00, en_a, en_b});
    chk_word("word a off", 12'h000, dat_a);
    wr(8'h05, 8'h03);
    wr(8'h14, 8'h20);
    repeat (4) tick();
    chk_reg("interleave", 8'h02, {6'h00, en_a, en_b});
    chk_word("word b muxed", 12'h000, dat_b);
    wa = exp_word(smp_a, 8'h80, 2'b00);
    wb = exp_word(smp_b, 8'h11, 2'b00);
    w0 = dat_a;
    tick();
    chk_reg("bus a word seen", 8'h01, {7'h00, (w0 === wa) || (w0 === wb)});
    chk_word("bus a alternates", (w0 === wa) ? wb : wa, dat_a);
    wr(8'h14, 8'h80);
    repeat (2) tick();
    chk_reg("level", 8'h02, {6'h00, lvl});
    wr(8'h33, 8'hff);
    rd(8'h14, 8'h80, "config after stray write");
    st_probe(8'h01, 8'h01);
    st_probe(8'h01, 8'h00);
    st_probe(8'h00, 8'h00);
    st_probe(8'hff, 8'h01);
    chk_reg("reinit", 8'h03, {6'h00, st_reinit});
    rd(8'h0e, 8'h05, "self test open bits");
    report_and_stop();
  end
endmodule : aocr_regs_tb

/* verilog/aocr_chan_path.sv */
// per-channel offset correction and output coding
module aocr_chan_path #(
  parameter int DATA_W = 12
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [DATA_W-1:0] sample_in,
  input wire logic [7:0] trim_in,
  input wire logic [1:0] format_in,
  output logic [DATA_W-1:0] word_out
);
  localparam logic signed [DATA_W+1:0] MAXV = (DATA_W+2)'((1 << DATA_W) - 1);
  logic signed [DATA_W+1:0] sum;
  logic [DATA_W-1:0] sat;
  logic [DATA_W-1:0] word_d;
  logic [DATA_W-1:0] word_q;

  always_comb begin
    // signed trim added in output lsbs, clamped to the code range
    sum = $signed({2'b00, sample_in}) + (DATA_W+2)'($signed(trim_in));
    if (sum < 0) begin
      sat = '0;
    end else if (sum > MAXV) begin
      sat = '1;
    end else begin
      sat = sum[DATA_W-1:0];
    end
    case (aocr_pkg::aocr_fmt_t'(format_in))
      aocr_pkg::AOCR_FMT_TWOS: word_d = {~sat[DATA_W-1], sat[DATA_W-2:0]};
      aocr_pkg::AOCR_FMT_GRAY: word_d = sat ^ (sat >> 1);
      default: word_d = sat;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      word_q <= '0;
    end else begin
      word_q <= word_d;
    end
  end

  assign word_out = word_q;

  a_twos_flip: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    format_in == 2'b01 && $stable(format_in) |=> word_q[DATA_W-1] == ~$past(sat[DATA_W-1]))
    else $error("twos complement msb not inverted");
endmodule : aocr_chan_path

/* verilog/aocr_pkg.sv */
// shared constants for the output configuration register bank
package aocr_pkg;
  localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0e;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_CONFIG = 8'h14;
  localparam logic [7:0] RST_CHAN_INDEX = 8'h03;
  localparam logic [7:0] RST_SELF_TEST = 8'h00;
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CONFIG = 8'h00;
  localparam int SELF_TEST_RUN_BIT = 0;
  localparam int SELF_TEST_REINIT_BIT = 2;
  localparam int OUT_DISABLE_BIT = 4;
  localparam int OUT_INTERLEAVE_BIT = 5;
  localparam int NUM_CHANNELS = 2;
  typedef enum logic [1:0] {
    AOCR_FMT_OFFSET_BIN = 2'b00,
    AOCR_FMT_TWOS = 2'b01,
    AOCR_FMT_GRAY = 2'b10,
    AOCR_FMT_OFFSET_BIN2 = 2'b11
  } aocr_fmt_t;
  typedef enum logic [1:0] {
    AOCR_LVL_3V3 = 2'b00,
    AOCR_LVL_RSVD1 = 2'b01,
    AOCR_LVL_1V8 = 2'b10,
    AOCR_LVL_RSVD3 = 2'b11
  } aocr_lvl_t;
endpackage : aocr_pkg

/* verilog/aocr_regs.sv */
// output configuration register bank of a dual-channel converter
module aocr_regs #(
  parameter int DATA_W = 12
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic [DATA_W-1:0] sample_a_in,
  input wire logic [DATA_W-1:0] sample_b_in,
  output logic [7:0] rd_data_out,
  output logic [DATA_W-1:0] data_a_out,
  output logic [DATA_W-1:0] data_b_out,
  output logic data_a_en_out,
  output logic data_b_en_out,
  output logic [1:0] self_test_start_out,
  output logic [1:0] self_test_reinit_out,
  output logic [1:0] io_level_out
);
  localparam int N = aocr_pkg::NUM_CHANNELS;
  logic [7:0] chan_idx_q, chan_idx_d;
  logic [7:0] st_q [N];
  logic [7:0] st_d [N];
  logic [7:0] trim_q [N];
  logic [7:0] trim_d [N];
  logic [7:0] ocfg_q [N];
  logic [7:0] ocfg_d [N];
  logic [7:0] rd_d, rd_q;
  logic [DATA_W-1:0] word [N];
  logic [DATA_W-1:0] a_d, b_d, a_q, b_q;
  logic a_en_d, b_en_d, a_en_q, b_en_q;
  logic [1:0] start_d, start_q, reinit_d, reinit_q;
  logic [1:0] lvl_d, lvl_q;
  logic phase_q, phase_d;
  logic [0:0] rd_ch;

  // per-channel config banks written only when the index bit is set
  always_comb begin
    chan_idx_d = chan_idx_q;
    if (wr_en_in && wr_addr_in == aocr_pkg::ADDR_CHAN_INDEX) begin
      chan_idx_d = {6'h00, wr_data_in[1:0]};
    end
  end

  for (genvar c = 0; c < N; c++) begin : g_ch
    logic hit;
    always_comb begin
      hit = wr_en_in && chan_idx_q[c];
      st_d[c] = st_q[c];
      trim_d[c] = trim_q[c];
      ocfg_d[c] = ocfg_q[c];
      if (hit && wr_addr_in == aocr_pkg::ADDR_SELF_TEST) begin
        st_d[c] = {5'h00, wr_data_in[2], 1'b0, wr_data_in[0]};
      end
      if (hit && wr_addr_in == aocr_pkg::ADDR_OFFSET_TRIM) begin
        trim_d[c] = wr_data_in;
      end
      if (hit && wr_addr_in == aocr_pkg::ADDR_OUTPUT_CONFIG) begin
        ocfg_d[c] = {wr_data_in[7:4], 1'b0, wr_data_in[2:0]};
      end
    end
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        st_q[c] <= aocr_pkg::RST_SELF_TEST;
        trim_q[c] <= aocr_pkg::RST_OFFSET_TRIM;
        ocfg_q[c] <= aocr_pkg::RST_OUTPUT_CONFIG;
      end else begin
        st_q[c] <= st_d[c];
        trim_q[c] <= trim_d[c];
        ocfg_q[c] <= ocfg_d[c];
      end
    end
    aocr_chan_path #(.DATA_W(DATA_W)) u_path (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .sample_in(c == 0 ? sample_a_in : sample_b_in),
      .trim_in(trim_q[c]),
      .format_in(ocfg_q[c][1:0]),
      .word_out(word[c])
    );
  end

  // readback shows the first selected channel; bit 0 of the index wins
  always_comb begin
    rd_ch = chan_idx_q[0] ? 1'b0 : 1'b1;
    rd_d = rd_q;
    if (rd_en_in) begin
      case (rd_addr_in)
        aocr_pkg::ADDR_CHAN_INDEX: rd_d = chan_idx_q;
        aocr_pkg::ADDR_SELF_TEST: rd_d = st_q[rd_ch];
        aocr_pkg::ADDR_OFFSET_TRIM: rd_d = trim_q[rd_ch];
        aocr_pkg::ADDR_OUTPUT_CONFIG: rd_d = ocfg_q[rd_ch];
        default: rd_d = 8'h00;
      endcase
    end
  end

  // output stage: disable, interleave, level, self-test start pulse
  always_comb begin
    a_en_d = ~ocfg_q[0][aocr_pkg::OUT_DISABLE_BIT];
    b_en_d = ~ocfg_q[1][aocr_pkg::OUT_DISABLE_BIT];
    a_d = a_en_d ? word[0] : '0;
    b_d = b_en_d ? word[1] : '0;
    if (ocfg_q[0][aocr_pkg::OUT_INTERLEAVE_BIT]) begin
      // interleaved: bus a alternates a then b words, bus b parked
      a_d = phase_q ? (b_en_d ? word[1] : '0) : (a_en_d ? word[0] : '0);
      b_d = '0;
      b_en_d = 1'b0;
      a_en_d = 1'b1;
    end
    // start is a one-cycle pulse on the rising edge of the enable bit
    for (int c = 0; c < N; c++) begin
      start_d[c] = st_q[c][aocr_pkg::SELF_TEST_RUN_BIT] & ~start_q[c] & ~reinit_q[c];
      // armed flag so the pulse fires once per set of the bit
      reinit_d[c] = st_q[c][aocr_pkg::SELF_TEST_RUN_BIT];
    end
    lvl_d = ocfg_q[0][7:6];
    phase_d = ~phase_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      chan_idx_q <= aocr_pkg::RST_CHAN_INDEX;
      rd_q <= 8'h00;
      a_q <= '0;
      b_q <= '0;
      a_en_q <= 1'b0;
      b_en_q <= 1'b0;
      start_q <= 2'b00;
      reinit_q <= 2'b00;
      lvl_q <= 2'b00;
      phase_q <= 1'b0;
    end else begin
      chan_idx_q <= chan_idx_d;
      rd_q <= rd_d;
      a_q <= a_d;
      b_q <= b_d;
      a_en_q <= a_en_d;
      b_en_q <= b_en_d;
      start_q <= start_d;
      reinit_q <= reinit_d;
      lvl_q <= lvl_d;
      phase_q <= phase_d;
    end
  end

  assign rd_data_out = rd_q;
  assign data_a_out = a_q;
  assign data_b_out = b_q;
  assign data_a_en_out = a_en_q;
  assign data_b_en_out = b_en_q;
  assign self_test_start_out = start_q;
  assign self_test_reinit_out = {st_q[1][aocr_pkg::SELF_TEST_REINIT_BIT], st_q[0][aocr_pkg::SELF_TEST_REINIT_BIT]};
  assign io_level_out = lvl_q;

  sequence s_st_write(int c);
    wr_en_in && wr_addr_in == aocr_pkg::ADDR_SELF_TEST && wr_data_in[0] && chan_idx_q[c] && !st_q[c][0];
  endsequence

  sequence s_ilv_live;
    ocfg_q[0][aocr_pkg::OUT_INTERLEAVE_BIT] && !ocfg_q[0][aocr_pkg::OUT_DISABLE_BIT] &&
      !ocfg_q[1][aocr_pkg::OUT_DISABLE_BIT];
  endsequence

  a_st_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_st_write(0) |-> ##2 self_test_start_out[0] ##1 !self_test_start_out[0])
    else $error("self-test start pulse missing");
  a_trim_store: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_en_in && wr_addr_in == aocr_pkg::ADDR_OFFSET_TRIM && chan_idx_q[1] |=> trim_q[1] == $past(wr_data_in))
    else $error("trim write not stored");
  a_trim_masked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !chan_idx_q[0] |=> $stable(trim_q[0]))
    else $error("unselected channel changed");
  a_level_map: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_en_in && wr_addr_in == aocr_pkg::ADDR_OUTPUT_CONFIG && chan_idx_q[0] |->
      ##2 io_level_out == $past(wr_data_in[7:6], 2))
    else $error("io level not following config");
  a_out_disable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ocfg_q[1][4] && !ocfg_q[0][5] |=> !data_b_en_out && data_b_out == '0)
    else $error("disabled output still driving");
  a_idx_reset: assert property (@(posedge sys_clk_in)
    $fell(rst_in) |-> chan_idx_q == 8'h03)
    else $error("channel index reset wrong");
  a_fmt_pass: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ocfg_q[0][1:0] == 2'b00 && !ocfg_q[0][4] && !ocfg_q[0][5] |=> data_a_out == $past(word[0]))
    else $error("offset binary path altered");
  a_trim_clamp: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    trim_q[0] == 8'h80 && sample_a_in == '0 && ocfg_q[0][1:0] == 2'b00 |-> ##1 word[0] == '0)
    else $error("negative trim not clamped");
  a_st_rearm: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    reinit_q[0] |=> !self_test_start_out[0])
    else $error("self-test start repeated while bit held");
  a_st_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !st_q[0][aocr_pkg::SELF_TEST_RUN_BIT] |=> !self_test_start_out[0])
    else $error("self-test start without enable bit");
  a_idx_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr_en_in && wr_addr_in == aocr_pkg::ADDR_CHAN_INDEX |=> chan_idx_q == {6'h00, $past(wr_data_in[1:0])})
    else $error("channel index write not stored");
  a_idx_local_b: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !chan_idx_q[1] |=> $stable(ocfg_q[1]) && $stable(st_q[1]))
    else $error("unselected channel b config changed");
  a_rd_index: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rd_en_in && rd_addr_in == aocr_pkg::ADDR_CHAN_INDEX |=> rd_data_out == $past(chan_idx_q))
    else $error("channel index readback wrong");
  a_ilv_buses: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ocfg_q[0][aocr_pkg::OUT_INTERLEAVE_BIT] |=> data_a_en_out && !data_b_en_out && data_b_out == '0)
    else $error("interleave bus enables wrong");
  a_ilv_odd: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_ilv_live ##0 phase_q |=> data_a_out == $past(word[1]))
    else $error("interleave odd slot not channel b");
  a_ilv_even: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_ilv_live ##0 !phase_q |=> data_a_out == $past(word[0]))
    else $error("interleave even slot not channel a");
  a_disable_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ocfg_q[0][aocr_pkg::OUT_DISABLE_BIT] && !ocfg_q[0][aocr_pkg::OUT_INTERLEAVE_BIT] |=>
      !data_a_en_out && data_a_out == '0)
    else $error("disabled output a still driving");
  a_lvl_reset: assert property (@(posedge sys_clk_in)
    $fell(rst_in) |-> io_level_out == 2'b00 && self_test_start_out == 2'b00)
    else $error("level or start not cleared by reset");
endmodule : aocr_regs
